// File: aci_pkg.sv
package aci_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NLINES = 4;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int RES_W = 16;
    localparam int STAT_W = 8;
    localparam int ACC_W = 5;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [AW-1:0] OFF_FLAG = 8'h00;
    localparam logic [AW-1:0] OFF_FLAG_CLR = 8'h04;
    localparam logic [AW-1:0] OFF_OVF = 8'h08;
    localparam logic [AW-1:0] OFF_OVF_CLR = 8'h0C;
    localparam logic [AW-1:0] OFF_SEL12 = 8'h10;
    localparam logic [AW-1:0] OFF_SEL34 = 8'h14;
    localparam logic [AW-1:0] OFF_CTL2 = 8'h18;
    localparam logic [AW-1:0] OFF_RESULT = 8'h1C;
    localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h24;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CONT_A_BIT = 0;
    localparam int CONT_B_BIT = 1;
    localparam int PS_LSB = 0;
    localparam int PS_W = 4;
    localparam int LATE_BIT = 4;
    localparam int ST_OVF_LSB = 4;

    // ----------------------------------------
    // Reset values and divider constants
    // ----------------------------------------
    localparam logic [NLINES-1:0] RST_LINES = 4'h0;
    localparam logic [PS_W-1:0] RST_PS = 4'h0;
    localparam logic [STAT_W-1:0] RST_STAT = 8'h00;
    localparam logic [RES_W-1:0] RST_RESULT = 16'h0000;
    localparam logic [ACC_W-1:0] RST_ACC = 5'h00;
    localparam logic [ACC_W-1:0] DIV_STEP = 5'h02;
    localparam logic [ACC_W-1:0] DIV_BASE = 5'h02;
    localparam logic [PS_W-1:0] PS_DIV10 = 4'h0;
    localparam logic [PS_W-1:0] PS_DIV15 = 4'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // AXI4-Lite carriers
    // ----------------------------------------
    typedef struct packed {
        logic [AW-1:0] awaddr;
        logic awvalid;
        logic [DW-1:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } aci_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DW-1:0] rdata;
        logic [1:0] rresp;
    } aci_axi_rsp_t;

    localparam aci_axi_rsp_t RSP_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// File: aci_top.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Without continue bit, no new line pulse while its flag is set.
// - Flag set by an event wins over a same-cycle clear write.
// - With continue bit set, every event pulses the line regardless of flag.
// - Four continue bits; lines 1-2 in one select register, 3-4 in another.
// - Event on a line with flag already set raises its overflow flag.
// - Writing one to the flag-clear bit clears the flag; software rechecks overflow.
// - Overflow stays set until a one is written to overflow-clear.
// - Conv_clock_divider field 3:0 divides system clock by 1.0 to 8.5 in steps of 0.5.
// - Late mode pulse may precede result latch by one or more cycles.
module aci_top
    import aci_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire aci_axi_req_t axi_req,
    output var aci_axi_rsp_t axi_rsp,
    input wire logic [NLINES-1:0] eoc_event,
    input wire logic result_valid,
    input wire logic [RES_W-1:0] result_data,
    output logic [NLINES-1:0] conversion_irq,
    output logic converter_clock,
    output logic late_irq_mode,
    output logic irq
);

    // ----------------------------------------
    // Register bus, line and control state
    // ----------------------------------------
    logic aw_got, w_got, next_aw_got, next_w_got, wr_do;
    logic [AW-1:0] awaddr_q, next_awaddr;
    logic [DW-1:0] wdata_q, next_wdata;
    logic [3:0] wstrb_q, next_wstrb;
    aci_axi_rsp_t next_rsp;
    logic [NLINES-1:0] flag, pend, ovf, cont, next_flag, next_pend, next_ovf, next_cont, next_conv_irq;
    logic [NLINES-1:0] flag_clr, ovf_clr, busy, issue, ovf_set, flag_set, rv_all, late_all;
    logic [PS_W-1:0] conv_clock_divider, next_conv_clock_divider;
    logic [RES_W-1:0] result, next_result;
    logic [STAT_W-1:0] stat, mask, next_stat, next_mask;
    logic [ACC_W-1:0] acc, next_acc, div_n, div_sum;
    logic next_late, next_conv_clk, next_irq, wr_en;

    function automatic logic addr_ok(input logic [AW-1:0] a);
        addr_ok = (a[1:0] == WORD_ALIGN) && (a <= OFF_IRQ_MASK);
    endfunction

    function automatic logic [DW-1:0] rd_word(input logic [AW-1:0] a);
        rd_word = '0;
        case (a)
            OFF_FLAG: rd_word[NLINES-1:0] = flag;
            OFF_OVF: rd_word[NLINES-1:0] = ovf;
            OFF_SEL12:
            begin
                rd_word[CONT_A_BIT] = cont[0];
                rd_word[CONT_B_BIT] = cont[1];
            end
            OFF_SEL34:
            begin
                rd_word[CONT_A_BIT] = cont[2];
                rd_word[CONT_B_BIT] = cont[3];
            end
            OFF_CTL2:
            begin
                rd_word[PS_LSB +: PS_W] = conv_clock_divider;
                rd_word[LATE_BIT] = late_irq_mode;
            end
            OFF_RESULT: rd_word[RES_W-1:0] = result;
            OFF_IRQ_STAT: rd_word[STAT_W-1:0] = stat;
            OFF_IRQ_MASK: rd_word[STAT_W-1:0] = mask;
            default: rd_word = '0;
        endcase
    endfunction

    // ----------------------------------------
    // AXI4-Lite slave, one write and one read at a time
    // ----------------------------------------
    always_comb
    begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_awaddr = awaddr_q;
        next_wdata = wdata_q;
        next_wstrb = wstrb_q;
        next_rsp = axi_rsp;
        wr_do = aw_got && w_got && !axi_rsp.bvalid;
        if (axi_req.awvalid && axi_rsp.awready)
        begin
            next_aw_got = 1'b1;
            next_awaddr = axi_req.awaddr;
            next_rsp.awready = 1'b0;
        end
        if (axi_req.wvalid && axi_rsp.wready)
        begin
            next_w_got = 1'b1;
            next_wdata = axi_req.wdata;
            next_wstrb = axi_req.wstrb;
            next_rsp.wready = 1'b0;
        end
        if (wr_do)
        begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_rsp.bvalid = 1'b1;
            next_rsp.bresp = addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        if (axi_rsp.bvalid && axi_req.bready)
        begin
            next_rsp.bvalid = 1'b0;
            next_rsp.awready = 1'b1;
            next_rsp.wready = 1'b1;
        end
        if (axi_req.arvalid && axi_rsp.arready)
        begin
            next_rsp.arready = 1'b0;
            next_rsp.rvalid = 1'b1;
            next_rsp.rdata = rd_word(axi_req.araddr);
            next_rsp.rresp = addr_ok(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (axi_rsp.rvalid && axi_req.rready)
        begin
            next_rsp.rvalid = 1'b0;
            next_rsp.arready = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            axi_rsp <= RSP_RST;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            awaddr_q <= next_awaddr;
            wdata_q <= next_wdata;
            wstrb_q <= next_wstrb;
            axi_rsp <= next_rsp;
        end
    end

    // ----------------------------------------
    // Conversion lines, flags, divider
    // ----------------------------------------
    // Only byte lane 0 carries writable bits
    assign wr_en = wr_do && wstrb_q[0] && addr_ok(awaddr_q);
    assign flag_clr = (wr_en && awaddr_q == OFF_FLAG_CLR) ? wdata_q[NLINES-1:0] : RST_LINES;
    assign ovf_clr = (wr_en && awaddr_q == OFF_OVF_CLR) ? wdata_q[NLINES-1:0] : RST_LINES;
    assign rv_all = {NLINES{result_valid}};
    assign late_all = {NLINES{late_irq_mode}};
    // Pending counts as set so late mode cannot slip a second pulse through
    assign busy = flag | pend;
    assign issue = eoc_event & (cont | ~busy);
    assign ovf_set = eoc_event & busy;
    // Late mode holds the flag back until a result is latched after the event cycle
    assign flag_set = (pend & rv_all) | (eoc_event & ~late_all);
    assign div_n = DIV_BASE + {1'b0, conv_clock_divider};
    assign div_sum = acc + DIV_STEP;

    always_comb
    begin
        next_pend = (pend & ~rv_all) | (eoc_event & late_all);
        next_flag = (flag & ~flag_clr) | flag_set;
        next_ovf = (ovf & ~ovf_clr) | ovf_set;
        next_conv_irq = issue;
        next_cont = cont;
        next_conv_clock_divider = conv_clock_divider;
        next_late = late_irq_mode;
        next_mask = mask;
        next_stat = (stat & ~((wr_en && awaddr_q == OFF_IRQ_STAT) ? wdata_q[STAT_W-1:0] : RST_STAT));
        next_stat = next_stat | {ovf_set, issue};
        next_result = result_valid ? result_data : result;
        next_irq = |(stat & mask);
        if (wr_en)
        begin
            case (awaddr_q)
                OFF_SEL12:
                begin
                    next_cont[0] = wdata_q[CONT_A_BIT];
                    next_cont[1] = wdata_q[CONT_B_BIT];
                end
                OFF_SEL34:
                begin
                    next_cont[2] = wdata_q[CONT_A_BIT];
                    next_cont[3] = wdata_q[CONT_B_BIT];
                end
                OFF_CTL2:
                begin
                    next_conv_clock_divider = wdata_q[PS_LSB +: PS_W];
                    next_late = wdata_q[LATE_BIT];
                end
                OFF_IRQ_MASK: next_mask = wdata_q[STAT_W-1:0];
                default: next_mask = mask;
            endcase
        end
        // Fractional divider: ticks average 2 per (conv_clock_divider+2) cycles
        next_conv_clk = 1'b0;
        next_acc = div_sum;
        if (div_sum >= div_n)
        begin
            next_acc = div_sum - div_n;
            next_conv_clk = 1'b1;
        end
        // Restart resets phase only; this tick keeps the old ratio so divide by one never skips
        if (wr_en && awaddr_q == OFF_CTL2)
        begin
            next_acc = RST_ACC;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag <= RST_LINES;
            pend <= RST_LINES;
            ovf <= RST_LINES;
            cont <= RST_LINES;
            conv_clock_divider <= RST_PS;
            late_irq_mode <= 1'b0;
            conversion_irq <= RST_LINES;
            result <= RST_RESULT;
            stat <= RST_STAT;
            mask <= RST_STAT;
            acc <= RST_ACC;
            converter_clock <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            flag <= next_flag;
            pend <= next_pend;
            ovf <= next_ovf;
            cont <= next_cont;
            conv_clock_divider <= next_conv_clock_divider;
            late_irq_mode <= next_late;
            conversion_irq <= next_conv_irq;
            result <= next_result;
            stat <= next_stat;
            mask <= next_mask;
            acc <= next_acc;
            converter_clock <= next_conv_clk;
            irq <= next_irq;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_sel_write;
        wr_en && awaddr_q == OFF_SEL34 |=> cont[3:2] == $past(wdata_q[1:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select write lost");
    property p_div_one;
        (conv_clock_divider == PS_DIV10) [*2] |=> converter_clock;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one missed tick");
    property p_div_frac;
        (conv_clock_divider == PS_DIV15) [*4] |-> converter_clock || $past(converter_clock);
    endproperty
    a_div_frac: assert property (p_div_frac) else $error("divide by 1.5 gap");
    property p_reset_zero;
        $rose(rst_n) |-> flag == RST_LINES && ovf == RST_LINES && cont == RST_LINES && conv_clock_divider == RST_PS;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("state not zero at reset");

    genvar i;
    generate
        for (i = 0; i < NLINES; i++)
        begin : g_chk
            sequence s_late_ev;
                late_irq_mode && eoc_event[i] && !busy[i] && !result_valid;
            endsequence
            sequence s_pulse_only;
                conversion_irq[i] && !flag[i];
            endsequence
            property p_blocked;
                eoc_event[i] && !cont[i] && busy[i] |=> !conversion_irq[i];
            endproperty
            a_blocked: assert property (p_blocked) else $error("pulse while flag set");
            property p_set_wins;
                eoc_event[i] && !late_irq_mode && flag_clr[i] |=> flag[i];
            endproperty
            a_set_wins: assert property (p_set_wins) else $error("clear beat the set");
            property p_cont;
                eoc_event[i] && cont[i] |=> conversion_irq[i];
            endproperty
            a_cont: assert property (p_cont) else $error("continue mode pulse missing");
            property p_ovf_set;
                eoc_event[i] && busy[i] |=> ovf[i];
            endproperty
            a_ovf_set: assert property (p_ovf_set) else $error("overflow not raised");
            property p_flag_clr;
                flag_clr[i] && !eoc_event[i] && !(pend[i] && result_valid) |=> !flag[i];
            endproperty
            a_flag_clr: assert property (p_flag_clr) else $error("flag clear ignored");
            property p_ovf_keep;
                ovf[i] && !ovf_clr[i] |=> ovf[i];
            endproperty
            a_ovf_keep: assert property (p_ovf_keep) else $error("overflow dropped early");
            property p_late;
                s_late_ev |=> s_pulse_only;
            endproperty
            a_late: assert property (p_late) else $error("late pulse not ahead of latch");
            property p_fresh;
                $rose(flag[i]) && $past(late_irq_mode) && !$past(eoc_event[i])
                    |-> $past(result_valid) && result == $past(result_data);
            endproperty
            a_fresh: assert property (p_fresh) else $error("flag before new result");
            property p_pulse;
                conversion_irq[i] |-> $past(eoc_event[i]) ##1 (!conversion_irq[i] || $past(eoc_event[i]));
            endproperty
            a_pulse: assert property (p_pulse) else $error("line pulse malformed");
        end
    endgenerate

endmodule

`default_nettype wire

// File: aci_conv_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Conversion core stand-in
// ----------------------------------------
module aci_conv_model
    import aci_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [NLINES-1:0] start,
    input wire logic [3:0] gap,
    input wire logic [RES_W-1:0] value,
    output logic [NLINES-1:0] eoc_event,
    output logic result_valid,
    output logic [RES_W-1:0] result_data
);
    logic [3:0] cnt;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eoc_event <= '0;
            result_valid <= 1'b0;
            result_data <= '0;
            cnt <= 4'h0;
        end
        else
        begin
            eoc_event <= start;
            result_valid <= 1'b0;
            // Off-strobe data never repeats the last value
            result_data <= ~result_data;
            cnt <= (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
            // Gap zero: result with the event; else result trails it
            if ((start != '0 && gap == 4'h0) || cnt == 4'h1)
            begin
                result_valid <= 1'b1;
                result_data <= value;
            end
            if (start != '0 && gap != 4'h0)
            begin
                cnt <= gap;
            end
        end
    end
endmodule

`default_nettype wire

// File: adc_interrupt_result_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none

module adc_interrupt_result_logic_tb;
    import aci_pkg::*;
    typedef struct {string nm; logic [DW-1:0] v; logic [1:0] r;} aci_exp_t;
    logic sys_clk, rst_n, rv, conv_clk, late, irq;
    aci_axi_req_t req;
    aci_axi_rsp_t rsp;
    logic [NLINES-1:0] start, eoc, irq_line;
    logic [RES_W-1:0] rdat, val, old_val;
    logic [3:0] gap;
    int n_fail, n_compared, seed, ticks;
    int pulses [NLINES];
    aci_exp_t q [$];
    logic [AW-1:0] rst_offs [6] = '{OFF_FLAG, OFF_OVF, OFF_SEL12, OFF_SEL34, OFF_CTL2, OFF_IRQ_MASK};

    aci_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp), .eoc_event(eoc),
        .result_valid(rv), .result_data(rdat), .conversion_irq(irq_line), .converter_clock(conv_clk),
        .late_irq_mode(late), .irq(irq));
    aci_conv_model MODEL (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .gap(gap), .value(val),
        .eoc_event(eoc), .result_valid(rv), .result_data(rdat));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Monitor: settled values, sampled mid-cycle
    // ----------------------------------------
    always @(negedge sys_clk)
    begin
        aci_exp_t e;
        for (int i = 0; i < NLINES; i++) pulses[i] += int'(irq_line[i]);
        ticks += int'(conv_clk);
        if (req.rready && rsp.rvalid)
        begin
            e = q.pop_front();
            chk(e.nm, rsp.rdata, e.v);
            chk({e.nm, " resp"}, 32'(rsp.rresp), 32'(e.r));
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] e);
        n_compared++;
        if (seen !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, seen);
        end
    endtask

    // Optional event lands on the edge where the write takes effect
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [NLINES-1:0] ev = '0);
        logic aw_hit, w_hit, b_hit;
        @(posedge sys_clk);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        start <= ev;
        do
        begin
            @(negedge sys_clk);
            aw_hit = req.awvalid && rsp.awready;
            w_hit = req.wvalid && rsp.wready;
            b_hit = req.bready && rsp.bvalid;
            if (b_hit) chk("bresp", 32'(rsp.bresp), 32'(RESP_OKAY));
            @(posedge sys_clk);
            start <= '0;
            if (aw_hit) req.awvalid <= 1'b0;
            if (w_hit) req.wvalid <= 1'b0;
            if (b_hit) req.bready <= 1'b0;
        end
        while (!b_hit);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [1:0] er = RESP_OKAY);
        logic ar_hit, r_hit;
        q.push_back('{$sformatf("reg %h", a), e, er});
        @(posedge sys_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            ar_hit = req.arvalid && rsp.arready;
            r_hit = req.rready && rsp.rvalid;
            @(posedge sys_clk);
            if (ar_hit) req.arvalid <= 1'b0;
            if (r_hit) req.rready <= 1'b0;
        end
        while (!r_hit);
    endtask

    task automatic fire(input logic [NLINES-1:0] m, input int settle);
        @(posedge sys_clk);
        old_val = val;
        val <= 16'($random(seed));
        start <= m;
        @(posedge sys_clk);
        start <= '0;
        repeat (settle) @(posedge sys_clk);
    endtask

    task automatic wait_pulse;
        int n;
        n = 0;
        while (irq_line[0] !== 1'b1 && n < 50)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("pulse wait", 32'(n < 50), 32'h1);
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && n_compared > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial
    begin
        #500000;
        n_fail++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        start = '0;
        gap = 4'h0;
        val = '0;
        seed = 56;
        n_fail = 0;
        n_compared = 0;
        ticks = 0;
        foreach (pulses[i]) pulses[i] = 0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rst_offs[i]) rd(rst_offs[i], 32'h0);
        rd(8'h28, 32'h0, RESP_SLVERR);
        // Sixty cycles hold whole periods of the four ratios tested here
        for (int v = 0; v < 4; v++)
        begin
            wr(OFF_CTL2, 32'(v));
            repeat (2) @(posedge sys_clk);
            ticks = 0;
            repeat (60) @(posedge sys_clk);
            chk("ticks", 32'(ticks), 32'(120 / (v + 2)));
        end
        wr(OFF_CTL2, 32'h0);
        fire(4'h1, 3);
        fire(4'h1, 3);
        chk("line0 pulses", 32'(pulses[0]), 32'h1);
        rd(OFF_FLAG, 32'h1);
        rd(OFF_OVF, 32'h1);
        wr(OFF_FLAG_CLR, 32'h1);
        rd(OFF_FLAG, 32'h0);
        rd(OFF_OVF, 32'h1);
        wr(OFF_OVF_CLR, 32'h1);
        rd(OFF_OVF, 32'h0);
        wr(OFF_FLAG_CLR, 32'h1, 4'h1);
        rd(OFF_FLAG, 32'h1);
        // Continue bit on line one and line four only
        wr(OFF_SEL12, 32'h1);
        wr(OFF_SEL34, 32'h2);
        rd(OFF_SEL12, 32'h1);
        rd(OFF_SEL34, 32'h2);
        foreach (pulses[i]) pulses[i] = 0;
        fire(4'hF, 3);
        fire(4'hF, 3);
        for (int i = 0; i < NLINES; i++)
        begin
            chk($sformatf("pulses %0d", i), 32'(pulses[i]), (i == 0 || i == 3) ? 32'h2 : 32'h1);
        end
        rd(OFF_OVF, 32'hF);
        rd(OFF_IRQ_STAT, 32'hFF);
        chk("irq masked", 32'(irq), 32'h0);
        wr(OFF_IRQ_MASK, 32'h10);
        repeat (2) @(posedge sys_clk);
        chk("irq raised", 32'(irq), 32'h1);
        wr(OFF_IRQ_STAT, 32'h10);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'(irq), 32'h0);
        rd(OFF_IRQ_STAT, 32'hEF);
        // Late mode, slow result
        wr(OFF_SEL12, 32'h0);
        wr(OFF_SEL34, 32'h0);
        wr(OFF_FLAG_CLR, 32'hF);
        wr(OFF_OVF_CLR, 32'hF);
        wr(OFF_CTL2, 32'h13);
        chk("late mode", 32'(late), 32'h1);
        gap <= 4'hA;
        fire(4'h1, 0);
        wait_pulse();
        rd(OFF_RESULT, 32'(old_val));
        rd(OFF_FLAG, 32'h0);
        repeat (12) @(posedge sys_clk);
        rd(OFF_FLAG, 32'h1);
        rd(OFF_RESULT, 32'(val));
        // First conversion is the dummy for a trigger-driven reader
        wr(OFF_FLAG_CLR, 32'h1);
        fire(4'h1, 0);
        wait_pulse();
        rd(OFF_RESULT, 32'(old_val));
        repeat (12) @(posedge sys_clk);
        rd(OFF_RESULT, 32'(val));
        tally_and_finish();
    end
endmodule

`default_nettype wire
